// ==== common/pwm_pkg.sv ====
// Contract
// RL1 - Duty is ten bits: high byte above two fraction bits from control bits 5:4.
// RL2 - High time equals duty times oscillator period times timer prescale factor.
// RL3 - Duty writes allowed anytime; loaded into active buffer only at period end.
// RL4 - In PWM mode the duty shadow byte ignores software writes.
// RL5 - Shadow byte plus hidden two-bit latch double-buffer the duty value.
// RL6 - Pin goes low when buffered duty equals timer count with two sub bits.
// RL7 - Duty beyond the period never matches, so the pin stays high.
// RL8 - Software sets period, duty, pin direction, timer, then PWM mode, in order.
// RL9 - Timer2 prescale factors are one, four and sixteen.
// RL10 - Timer2 control holds prescale select and run enable; timer must run.
// RL11 - Usable resolution is log2 of oscillator over PWM frequency, at most ten.
// RL12 - After count equals period: clear timer, set pin unless zero duty, latch duty.
// RL13 - Period is period register plus one, times four, times prescale factor.
// RL14 - Clearing the whole unit control register forces the PWM latch low.
// RL15 - PWM mode is entered when the four mode bits hold the PWM encoding.
// RL16 - Pin is driven only while its port direction bit selects output.
package pwm_pkg;
    localparam logic [7:0] OFF_INTCTL = 8'h0b;
    localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] OFF_T2_COUNT = 8'h11;
    localparam logic [7:0] OFF_T2_CTRL = 8'h12;
    localparam logic [7:0] OFF_DUTY_HIGH = 8'h15;
    localparam logic [7:0] OFF_DUTY_SHADOW = 8'h16;
    localparam logic [7:0] OFF_UNIT_CTRL = 8'h17;
    localparam logic [7:0] OFF_PORT_C_DIR = 8'h87;
    localparam logic [7:0] OFF_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0] OFF_T2_PERIOD = 8'h92;
    localparam logic [7:0] RST_T2_PERIOD = 8'hff;
    localparam logic [7:0] RST_PORT_C_DIR = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam int DIR_PWM_BIT = 2;
    localparam int T2_RUN_BIT = 2;
    localparam int T2_PS_LSB = 0;
    localparam int FRAC_LSB = 4;
    localparam logic [3:0] MODE_PWM_PATTERN = 4'hc;
    localparam logic [3:0] MODE_PWM_MASK = 4'hc;
    localparam logic [6:0] T2_CTRL_MASK = 7'h7f;
    localparam logic [5:0] UNIT_CTRL_MASK = 6'h3f;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // Four oscillator clocks make one instruction cycle.
    localparam int CLK_PER_INSTR = 4;
    localparam int CORE_CLK_MHZ = 200;
endpackage : pwm_pkg

// ==== common/timebase_if.sv ====
`timescale 1ns/10ps
// Time base shared between the timer and the duty comparator.
interface timebase_if;
    logic [7:0] count;
    logic [1:0] sub;
    logic rollover;
    logic running;
    modport timer (output count, output sub, output rollover, output running);
    modport comp (input count, input sub, input rollover, input running);
endinterface : timebase_if

// ==== src/timer2_base.sv ====
`timescale 1ns/10ps
// Timer2 counter with prescaler; sub bits extend the count by two.
module timer2_base
    import pwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run_en,
    input wire logic [1:0] ps_sel,
    input wire logic [7:0] period,
    input wire logic count_wr,
    input wire logic [7:0] count_wdata,
    timebase_if.timer tb
);
    logic [1:0] phase_reg;
    logic [3:0] pre_reg;
    logic [7:0] count_reg;
    logic instr_tick;
    logic pre_wrap;

    // One instruction cycle is four oscillator phases.
    assign instr_tick = (phase_reg == 2'(CLK_PER_INSTR - 1));
    // Prescale of one, four or sixteen instruction cycles.
    always_comb
    begin
        if (ps_sel == 2'b00)
            pre_wrap = 1'b1; // RL9
        else if (ps_sel == 2'b01)
            pre_wrap = (pre_reg[1:0] == 2'h3); // RL9
        else
            pre_wrap = (pre_reg == 4'hf); // RL9
    end

    // The phase and prescaler only move while the timer runs.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            phase_reg <= 2'h0;
            pre_reg <= 4'h0;
        end
        else if (!run_en || count_wr)
        begin
            phase_reg <= 2'h0;
            pre_reg <= 4'h0;
        end
        else
        begin
            phase_reg <= phase_reg + 2'h1;
            if (instr_tick)
                pre_reg <= pre_wrap ? 4'h0 : pre_reg + 4'h1;
        end
    end

    // Counter clears on the increment after it equals the period.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            count_reg <= 8'h00;
        else if (count_wr)
            count_reg <= count_wdata;
        else if (run_en && instr_tick && pre_wrap) // RL10
            count_reg <= (count_reg == period) ? 8'h00 : count_reg + 8'h01; // RL12 RL13
    end

    assign tb.count = count_reg;
    // Low bits are the quarter phase at prescale one, else the prescaler step worth one duty unit.
    assign tb.sub = (ps_sel == 2'b00) ? phase_reg :
        ((ps_sel == 2'b01) ? pre_reg[1:0] : pre_reg[3:2]); // RL6
    assign tb.rollover = run_en && instr_tick && pre_wrap && (count_reg == period);
    assign tb.running = run_en;
endmodule : timer2_base

// ==== src/duty_compare.sv ====
`timescale 1ns/10ps
// Double-buffered duty register and output latch.
module duty_compare
    import pwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pwm_mode,
    input wire logic unit_clear,
    input wire logic [7:0] duty_high,
    input wire logic [1:0] duty_frac,
    input wire logic shadow_wr,
    input wire logic [7:0] shadow_wdata,
    timebase_if.comp tb,
    output logic [7:0] shadow_byte,
    output logic pwm_level
);
    logic [7:0] shadow_reg;
    logic [1:0] frac_latch_reg;
    logic level_reg;
    logic [9:0] active_duty;
    logic [9:0] next_duty;
    logic duty_match;

    assign active_duty = {shadow_reg, frac_latch_reg}; // RL5
    assign next_duty = {duty_high, duty_frac}; // RL1
    // Match is judged on the live time base so pwm_level drops in the matching cycle itself.
    assign duty_match = tb.running && ({tb.count, tb.sub} == active_duty); // RL6

    // In PWM mode load the buffers only at period end so a period never sees a torn value.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            shadow_reg <= 8'h00;
            frac_latch_reg <= 2'h0;
        end
        else if (pwm_mode && tb.rollover)
        begin
            shadow_reg <= duty_high; // RL3 RL12
            frac_latch_reg <= duty_frac; // RL5
        end
        else if (shadow_wr && !pwm_mode)
            shadow_reg <= shadow_wdata; // RL4
    end

    // Set at period restart, clear on match; unmatched duty stays high.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || unit_clear)
            level_reg <= 1'b0; // RL14
        else if (!pwm_mode)
            level_reg <= 1'b0; // RL15
        else if (!tb.running)
            level_reg <= level_reg;
        else if (tb.rollover)
            level_reg <= (next_duty != 10'h000); // RL12
        else if (duty_match)
            level_reg <= 1'b0; // RL2 RL6 RL7 RL11
    end

    assign shadow_byte = shadow_reg;
    assign pwm_level = level_reg && pwm_mode && !duty_match; // RL2

    // Zero duty never raises the output at a restart.
    property p_zero_duty_low;
        @(posedge core_clk) disable iff (!rst_n)
        (pwm_mode && tb.running && tb.rollover && next_duty == 10'h000 && !unit_clear)
            |=> !level_reg;
    endproperty
    a_zero_duty_low: assert property (p_zero_duty_low) else $error("zero duty set pin"); // RL12

    property p_restart_sets;
        @(posedge core_clk) disable iff (!rst_n)
        (pwm_mode && tb.rollover && next_duty != 10'h000 && !unit_clear) |=> level_reg;
    endproperty
    a_restart_sets: assert property (p_restart_sets) else $error("restart did not set pin"); // RL12

    property p_latch_at_end;
        @(posedge core_clk) disable iff (!rst_n)
        (pwm_mode && tb.rollover) |=> (shadow_reg == $past(duty_high));
    endproperty
    a_latch_at_end: assert property (p_latch_at_end) else $error("duty not latched"); // RL3

    property p_shadow_locked;
        @(posedge core_clk) disable iff (!rst_n)
        (pwm_mode && !tb.rollover) |=> $stable(shadow_reg) || !$past(pwm_mode);
    endproperty
    a_shadow_locked: assert property (p_shadow_locked) else $error("shadow changed"); // RL4

    property p_match_clears;
        @(posedge core_clk) disable iff (!rst_n)
        (pwm_mode && tb.running && !tb.rollover && {tb.count, tb.sub} == active_duty)
            |=> !level_reg;
    endproperty
    a_match_clears: assert property (p_match_clears) else $error("match missed"); // RL6

    property p_clear_forces_low;
        @(posedge core_clk) disable iff (!rst_n)
        unit_clear |=> !level_reg;
    endproperty
    a_clear_forces_low: assert property (p_clear_forces_low) else $error("latch not low"); // RL14
endmodule : duty_compare

// ==== src/timer2_pwm_duty_engine.sv ====
`timescale 1ns/10ps
// Timer2 PWM engine with an AXI4-Lite register slave.
module timer2_pwm_duty_engine
    import pwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pwm_output_pin_o,
    output logic pwm_output_pin_oe
);
    // Byte address is four times the register index, so the index is bits 9:2.
    function automatic logic [7:0] word_idx(input logic [9:0] addr);
        word_idx = addr[9:2];
    endfunction : word_idx

    logic [7:0] intctl_reg;
    logic [7:0] irq_flags_reg;
    logic [7:0] irq_en_reg;
    logic [6:0] t2_ctrl_reg;
    logic [7:0] duty_high_reg;
    logic [5:0] unit_ctrl_reg;
    logic [7:0] port_dir_reg;
    logic [7:0] period_reg;
    logic [9:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic wr_go;
    logic wr_hit;
    logic [7:0] wr_idx;
    logic [7:0] wbyte;
    logic pwm_mode;
    logic unit_clear;
    logic count_wr;
    logic shadow_wr;
    logic [7:0] shadow_byte;
    logic pwm_level;
    logic rd_hit;
    logic [7:0] rd_byte;

    timebase_if tb ();

    // Address and data are taken independently; the write runs once both are held.
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_idx = word_idx(awaddr_reg);
    // Only the low byte lane carries register data.
    assign wbyte = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 10'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held_reg <= 1'b0;
        end
    end

    // Decode of writes; unmapped words answer with an error and change nothing.
    always_comb
    begin
        wr_hit = 1'b1;
        if (wr_idx == OFF_INTCTL || wr_idx == OFF_IRQ_FLAGS || wr_idx == OFF_IRQ_ENABLES)
            wr_hit = 1'b1;
        else if (wr_idx == OFF_T2_COUNT || wr_idx == OFF_T2_CTRL || wr_idx == OFF_DUTY_HIGH)
            wr_hit = 1'b1;
        else if (wr_idx == OFF_DUTY_SHADOW || wr_idx == OFF_UNIT_CTRL)
            wr_hit = 1'b1;
        else if (wr_idx == OFF_PORT_C_DIR || wr_idx == OFF_T2_PERIOD)
            wr_hit = 1'b1;
        else
            wr_hit = 1'b0;
    end

    // Byte strobe gating keeps a write with lane 0 off from touching a register.
    logic wr_en;
    assign wr_en = wr_go && wr_hit && wstrb_reg[0];
    assign count_wr = wr_en && (wr_idx == OFF_T2_COUNT);
    assign shadow_wr = wr_en && (wr_idx == OFF_DUTY_SHADOW);
    assign unit_clear = wr_en && (wr_idx == OFF_UNIT_CTRL) && (wbyte[5:0] == 6'h00); // RL14

    // Software-visible configuration registers.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            intctl_reg <= RST_ZERO;
            irq_flags_reg <= RST_ZERO;
            irq_en_reg <= RST_ZERO;
            t2_ctrl_reg <= RST_ZERO[6:0];
            duty_high_reg <= RST_ZERO;
            unit_ctrl_reg <= RST_ZERO[5:0];
            port_dir_reg <= RST_PORT_C_DIR;
            period_reg <= RST_T2_PERIOD;
        end
        else if (wr_en)
        begin
            if (wr_idx == OFF_INTCTL)
                intctl_reg <= wbyte;
            else if (wr_idx == OFF_IRQ_FLAGS)
                irq_flags_reg <= wbyte;
            else if (wr_idx == OFF_IRQ_ENABLES)
                irq_en_reg <= wbyte;
            else if (wr_idx == OFF_T2_CTRL)
                t2_ctrl_reg <= wbyte[6:0] & T2_CTRL_MASK; // RL10
            else if (wr_idx == OFF_DUTY_HIGH)
                duty_high_reg <= wbyte; // RL3
            else if (wr_idx == OFF_UNIT_CTRL)
                unit_ctrl_reg <= wbyte[5:0] & UNIT_CTRL_MASK; // RL1 RL15
            else if (wr_idx == OFF_PORT_C_DIR)
                port_dir_reg <= wbyte;
            else if (wr_idx == OFF_T2_PERIOD)
                period_reg <= wbyte; // RL13
        end
    end

    // Write response follows the accepted pair by one cycle.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= AXI_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Mode bits select PWM; the two-bit pattern match covers all four PWM encodings.
    assign pwm_mode = ((unit_ctrl_reg[3:0] & MODE_PWM_MASK) == MODE_PWM_PATTERN); // RL15

    timer2_base u_timer
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run_en(t2_ctrl_reg[T2_RUN_BIT]), // RL10
        .ps_sel(t2_ctrl_reg[T2_PS_LSB +: 2]), // RL9
        .period(period_reg),
        .count_wr(count_wr),
        .count_wdata(wbyte),
        .tb(tb)
    );

    duty_compare u_duty
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pwm_mode(pwm_mode),
        .unit_clear(unit_clear),
        .duty_high(duty_high_reg),
        .duty_frac(unit_ctrl_reg[FRAC_LSB +: 2]), // RL1
        .shadow_wr(shadow_wr),
        .shadow_wdata(wbyte),
        .tb(tb),
        .shadow_byte(shadow_byte),
        .pwm_level(pwm_level)
    );

    // Read decode; one read at a time, answered one cycle after acceptance.
    assign s_axi_arready = !rvalid_reg;
    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        if (word_idx(s_axi_araddr) == OFF_INTCTL)
            rd_byte = intctl_reg;
        else if (word_idx(s_axi_araddr) == OFF_IRQ_FLAGS)
            rd_byte = irq_flags_reg;
        else if (word_idx(s_axi_araddr) == OFF_IRQ_ENABLES)
            rd_byte = irq_en_reg;
        else if (word_idx(s_axi_araddr) == OFF_T2_COUNT)
            rd_byte = tb.count;
        else if (word_idx(s_axi_araddr) == OFF_T2_CTRL)
            rd_byte = {1'b0, t2_ctrl_reg};
        else if (word_idx(s_axi_araddr) == OFF_DUTY_HIGH)
            rd_byte = duty_high_reg;
        else if (word_idx(s_axi_araddr) == OFF_DUTY_SHADOW)
            rd_byte = shadow_byte;
        else if (word_idx(s_axi_araddr) == OFF_UNIT_CTRL)
            rd_byte = {2'b00, unit_ctrl_reg};
        else if (word_idx(s_axi_araddr) == OFF_PORT_C_DIR)
            rd_byte = port_dir_reg;
        else if (word_idx(s_axi_araddr) == OFF_T2_PERIOD)
            rd_byte = period_reg;
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_byte};
            rresp_reg <= rd_hit ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // The pin value always follows the PWM level; its enable needs PWM mode and a cleared direction bit.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pwm_output_pin_o <= 1'b0;
            pwm_output_pin_oe <= 1'b0;
        end
        else
        begin
            pwm_output_pin_o <= pwm_level;
            pwm_output_pin_oe <= pwm_mode && !port_dir_reg[DIR_PWM_BIT]; // RL16
        end
    end

    property p_pin_direction;
        @(posedge core_clk) disable iff (!rst_n)
        port_dir_reg[DIR_PWM_BIT] |=> !pwm_output_pin_oe;
    endproperty
    a_pin_direction: assert property (p_pin_direction) else $error("pin driven as input"); // RL16

    property p_period_wrap;
        @(posedge core_clk) disable iff (!rst_n)
        tb.rollover && !count_wr |=> (tb.count == 8'h00);
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("timer did not clear"); // RL12

    property p_stopped_timer;
        @(posedge core_clk) disable iff (!rst_n)
        (!t2_ctrl_reg[T2_RUN_BIT] && !count_wr) |=> $stable(tb.count);
    endproperty
    a_stopped_timer: assert property (p_stopped_timer) else $error("timer moved stopped"); // RL10
endmodule : timer2_pwm_duty_engine

// ==== testbench/tb_timer2_pwm_duty_engine.sv ====
`timescale 1ns/10ps
// Register bus and pin-timing bench for the PWM engine.
module tb_timer2_pwm_duty_engine;
    import pwm_pkg::*;

    logic core_clk;
    logic rst_n;
    logic [9:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [9:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic pwm_output_pin_o;
    logic pwm_output_pin_oe;
    int mismatches;
    int n_compared;
    int hi;
    int per;
    int edges;
    int f;

    timer2_pwm_duty_engine u_timer2_pwm_duty_engine (
        .core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pwm_output_pin_o(pwm_output_pin_o),
        .pwm_output_pin_oe(pwm_output_pin_oe)
    );

    // The 200 MHz core clock.
    initial
    begin
        core_clk = 1'b0;
        forever
            #2.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Handshakes are judged at the falling edge, so the outcome of the next rising edge is
    // known without racing the design's own flops.
    task automatic axi_wr(input logic [7:0] off, input logic [7:0] d, output logic [1:0] r);
        logic [9:0] a;
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        a = {off, 2'b00};
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (aw_hit)
                s_axi_awvalid <= 1'b0;
            if (w_hit)
                s_axi_wvalid <= 1'b0;
        end
        while (!b_hit);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] off, output logic [31:0] d, output logic [1:0] r);
        logic [9:0] a;
        logic ar_hit;
        logic r_hit;
        a = {off, 2'b00};
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ar_hit)
                s_axi_arvalid <= 1'b0;
        end
        while (!r_hit);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [7:0] off, input logic [7:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_wr(off, d, r);
        check("write response", {30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] off, input logic [7:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(off, d, r);
        check("read response", {30'h0, r}, {30'h0, er});
        check("read data", d, {24'h000000, ed});
    endtask : rd

    // Waits for a rising pin edge, then counts the high and whole-period cycles after it.
    task automatic measure(output int h, output int p);
        do
            @(negedge core_clk);
        while (pwm_output_pin_o !== 1'b0);
        do
            @(negedge core_clk);
        while (pwm_output_pin_o !== 1'b1);
        h = 0;
        while (pwm_output_pin_o === 1'b1)
        begin
            h++;
            @(negedge core_clk);
        end
        p = h;
        while (pwm_output_pin_o === 1'b0)
        begin
            p++;
            @(negedge core_clk);
        end
    endtask : measure

    task automatic window(input int n, output int h, output int e);
        logic last;
        h = 0;
        e = 0;
        @(negedge core_clk);
        last = pwm_output_pin_o;
        repeat (n)
        begin
            @(negedge core_clk);
            if (pwm_output_pin_o === 1'b1)
                h++;
            if (pwm_output_pin_o !== last)
                e++;
            last = pwm_output_pin_o;
        end
    endtask : window

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // A stuck handshake or a pin that never toggles is caught here.
    initial
    begin
        repeat (90000) @(posedge core_clk);
        mismatches++;
        $display("MISMATCH watchdog expected finish seen timeout");
        stop_test();
    end

    // Main sequence; the period register keeps its reset value, so a period is 1024 clocks
    // at prescale one.
    initial
    begin
        mismatches = 0;
        n_compared = 0;
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        check("pin after reset", {31'h0, pwm_output_pin_o}, 32'h0);
        rd(OFF_T2_CTRL, RST_ZERO, AXI_OKAY);
        rd(OFF_UNIT_CTRL, RST_ZERO, AXI_OKAY);
        rd(OFF_T2_COUNT, RST_ZERO, AXI_OKAY);
        rd(OFF_IRQ_FLAGS, RST_ZERO, AXI_OKAY);
        rd(OFF_IRQ_ENABLES, RST_ZERO, AXI_OKAY);
        rd(OFF_PORT_C_DIR, RST_PORT_C_DIR, AXI_OKAY);
        rd(OFF_T2_PERIOD, RST_T2_PERIOD, AXI_OKAY);
        rd(8'h00, RST_ZERO, AXI_SLVERR);
        wr(8'h01, 8'h5a, AXI_SLVERR);
        wr(OFF_DUTY_HIGH, 8'h20, AXI_OKAY);
        rd(OFF_DUTY_HIGH, 8'h20, AXI_OKAY);
        wr(OFF_UNIT_CTRL, 8'hd0, AXI_OKAY);
        rd(OFF_UNIT_CTRL, 8'h10, AXI_OKAY);
        wr(OFF_PORT_C_DIR, 8'hfb, AXI_OKAY);
        wr(OFF_T2_CTRL, 8'h84, AXI_OKAY);
        rd(OFF_T2_CTRL, 8'h04, AXI_OKAY);
        // Every PWM encoding of the mode bits gives the same waveform, duty 0x81.
        for (int m = 0; m < 4; m++)
        begin
            wr(OFF_UNIT_CTRL, 8'h1c | 8'(m), AXI_OKAY);
            measure(hi, per);
            check("high time", hi, 129);
            check("period", per, 1024);
            check("pin enable", {31'h0, pwm_output_pin_oe}, 32'h1);
        end
        // A duty write early in a period must wait for the period to end.
        wr(OFF_DUTY_HIGH, 8'h40, AXI_OKAY);
        rd(OFF_DUTY_SHADOW, 8'h20, AXI_OKAY);
        measure(hi, per);
        check("new high time", hi, 257);
        rd(OFF_DUTY_SHADOW, 8'h40, AXI_OKAY);
        wr(OFF_DUTY_SHADOW, 8'h55, AXI_OKAY);
        rd(OFF_DUTY_SHADOW, 8'h40, AXI_OKAY);
        // Prescale 4, then 16 through the upper select code.
        for (int s = 1; s < 3; s++)
        begin
            f = (s == 1) ? 4 : 16;
            wr(OFF_T2_CTRL, 8'h04 | 8'(2 * s - 1), AXI_OKAY);
            measure(hi, per);
            check("scaled high time", hi, 257 * f);
            check("scaled period", per, 1024 * f);
        end
        wr(OFF_T2_CTRL, 8'h04, AXI_OKAY);
        wr(OFF_DUTY_HIGH, 8'hff, AXI_OKAY);
        wr(OFF_UNIT_CTRL, 8'h3c, AXI_OKAY);
        measure(hi, per);
        measure(hi, per);
        check("largest duty", hi, 1023);
        check("largest duty period", per, 1024);
        // Zero duty must keep the pin low through whole periods.
        wr(OFF_DUTY_HIGH, 8'h00, AXI_OKAY);
        wr(OFF_UNIT_CTRL, 8'h0c, AXI_OKAY);
        window(2100, hi, edges);
        window(1100, hi, edges);
        check("zero duty high", hi, 0);
        wr(OFF_DUTY_HIGH, 8'h20, AXI_OKAY);
        wr(OFF_UNIT_CTRL, 8'h1c, AXI_OKAY);
        measure(hi, per);
        check("restored high time", hi, 129);
        // A stopped timer freezes the waveform and accepts a loaded count.
        wr(OFF_T2_CTRL, 8'h00, AXI_OKAY);
        window(2100, hi, edges);
        check("edges while stopped", edges, 0);
        wr(OFF_T2_COUNT, 8'h33, AXI_OKAY);
        rd(OFF_T2_COUNT, 8'h33, AXI_OKAY);
        wr(OFF_T2_CTRL, 8'h04, AXI_OKAY);
        measure(hi, per);
        check("resumed high time", hi, 129);
        wr(OFF_UNIT_CTRL, 8'h18, AXI_OKAY);
        window(2100, hi, edges);
        check("non PWM mode high", hi, 0);
        // Clearing the control register while the pin is high forces it low.
        wr(OFF_UNIT_CTRL, 8'h1c, AXI_OKAY);
        measure(hi, per);
        wr(OFF_UNIT_CTRL, 8'h00, AXI_OKAY);
        window(1100, hi, edges);
        check("cleared unit high", hi, 0);
        check("cleared pin enable", {31'h0, pwm_output_pin_oe}, 32'h0);
        rd(OFF_UNIT_CTRL, RST_ZERO, AXI_OKAY);
        stop_test();
    end
endmodule : tb_timer2_pwm_duty_engine
